/* design/evr_pkg.sv */
// Constants, register map and state types for the event router
package evr_pkg;

    // --------------------------------------------------------------
    // Sizes
    // --------------------------------------------------------------
    localparam int EVR_NUM_INT  = 8;                          // Internal event sources
    localparam int EVR_NUM_PIN  = 24;                         // Pins usable as GPIO
    localparam int EVR_NUM_IN   = EVR_NUM_INT + EVR_NUM_PIN;  // All inputs
    localparam int EVR_NUM_IRQ  = 4;                          // Interrupt outputs
    localparam int EVR_NUM_OUT  = EVR_NUM_IRQ + 1;            // Plus wake-up output
    localparam int EVR_WAKE_IDX = EVR_NUM_IRQ;                // Index of wake-up output
    localparam int EVR_AW       = 8;                          // Register address width
    localparam int EVR_DW       = 32;                         // Register data width
    localparam int EVR_SYNC_LEN = 2;                          // Synchroniser stages

    // --------------------------------------------------------------
    // Register byte offsets
    // --------------------------------------------------------------
    localparam logic [EVR_AW-1:0] EVR_OFS_POLARITY = 8'h00;  // 1 = active high
    localparam logic [EVR_AW-1:0] EVR_OFS_MODE     = 8'h04;  // 1 = latched, 0 = direct
    localparam logic [EVR_AW-1:0] EVR_OFS_GLOBAL   = 8'h08;  // 1 = input enabled
    localparam logic [EVR_AW-1:0] EVR_OFS_LATCH    = 8'h0C;  // Latched events, W1C
    localparam logic [EVR_AW-1:0] EVR_OFS_RAW      = 8'h10;  // Event condition per input
    localparam logic [EVR_AW-1:0] EVR_OFS_OUTEN    = 8'h20;  // Base of per-output enables
    localparam logic [EVR_AW-1:0] EVR_OFS_OUTST    = 8'h40;  // Base of per-output status
    localparam logic [EVR_AW-1:0] EVR_OFS_SUMMARY  = 8'h60;  // Output lines, low 5 bits
    localparam logic [EVR_AW-1:0] EVR_OFS_STRIDE   = 8'h04;  // Word stride in arrays

    // --------------------------------------------------------------
    // Reset values
    // --------------------------------------------------------------
    localparam logic [EVR_DW-1:0] EVR_RST_POLARITY = 32'hFFFFFFFF;
    localparam logic [EVR_DW-1:0] EVR_RST_MODE     = 32'h00000000;
    localparam logic [EVR_DW-1:0] EVR_RST_GLOBAL   = 32'h00000000;
    localparam logic [EVR_DW-1:0] EVR_RST_OUTEN    = 32'h00000000;
    localparam logic [EVR_DW-1:0] EVR_RST_ZERO     = 32'h00000000;

    // --------------------------------------------------------------
    // State types
    // --------------------------------------------------------------
    typedef logic [EVR_NUM_IN-1:0] evr_vec_t;

    typedef struct packed {
        evr_vec_t                        polarity;
        evr_vec_t                        mode;
        evr_vec_t                        globalEn;
        evr_vec_t                        latched;
        evr_vec_t                        prevLevel;
        logic [EVR_NUM_OUT-1:0][EVR_NUM_IN-1:0] outEn;
        logic [EVR_DW-1:0]               rdData;
    } evr_state_t;

    typedef struct packed {
        evr_vec_t stage1;
        evr_vec_t stage2;
    } evr_sync_state_t;

endpackage

/* design/evr_sync_if.sv */
// Interface between the event router core and its input synchroniser
`timescale 1ns/1ps
interface evr_sync_if;
    import evr_pkg::*;

    evr_vec_t rawIn;   // Unsynchronised event inputs
    evr_vec_t syncOut; // Inputs after two flip-flops

    modport sync (input rawIn, output syncOut);
    modport user (output rawIn, input syncOut);
endinterface

/* design/evr_sync.sv */
// Two-stage synchroniser bank for the event router inputs
`timescale 1ns/1ps
module evr_sync
    import evr_pkg::*;
(
    input  wire logic clk,       // System clock
    input  wire logic rst_b,     // Asynchronous reset, active low
    evr_sync_if.sync  syncPort   // Raw inputs in, synchronised out
);

    evr_sync_state_t st;
    evr_sync_state_t next_st;

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    // Stage two reads only stage one
    always_comb begin
        next_st        = st;
        next_st.stage1 = syncPort.rawIn;
        next_st.stage2 = st.stage1;
    end

    // State register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Synchronised level out
    assign syncPort.syncOut = st.stage2;

endmodule // evr_sync

/* design/event_router.sv */
// Event router: input events through masks to interrupt and wake-up lines
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps

module event_router
    import evr_pkg::*;
(
    input  wire logic                   clk,       // System clock, 100 MHz
    input  wire logic                   rst_b,     // Asynchronous reset, active low
    input  wire logic [EVR_NUM_INT-1:0] intEvIn,   // Internal event signals
    input  wire logic [EVR_NUM_PIN-1:0] pinEvIn,   // Pad levels of GPIO-capable pins
    input  wire logic [EVR_AW-1:0]      regAddr,   // Register byte address
    input  wire logic [EVR_DW-1:0]      regWrData, // Register write data
    input  wire logic                   regWr,     // Write strobe
    input  wire logic                   regRd,     // Read strobe
    output logic      [EVR_DW-1:0]      regRdData, // Read data, cycle after strobe
    output logic      [EVR_NUM_IRQ-1:0] irqOut,    // Interrupt lines, active high
    output logic                        wakeOut    // Wake-up line, active high
);

    // --------------------------------------------------------------
    // Helper functions
    // --------------------------------------------------------------

    // Input level turned into an active-high event condition
    function automatic evr_vec_t active_level(input evr_vec_t level,
                                              input evr_vec_t polarity);
        active_level = ~(level ^ polarity);
    endfunction

    // Condition per input: latched bit or live active level
    function automatic evr_vec_t event_cond(input evr_vec_t mode,
                                            input evr_vec_t latched,
                                            input evr_vec_t liveLevel);
        event_cond = (mode & latched) | (~mode & liveLevel);
    endfunction

    // Routing of all conditions onto every output line
    function automatic logic [EVR_NUM_OUT-1:0] route_out(
        input evr_vec_t                               cond,
        input evr_vec_t                               globalEn,
        input logic [EVR_NUM_OUT-1:0][EVR_NUM_IN-1:0] outEn);
        logic [EVR_NUM_OUT-1:0] lines;
        lines = '0;
        for (int k = 0; k < EVR_NUM_OUT; k++) begin
            lines[k] = |(cond & globalEn & outEn[k]);
        end
        route_out = lines;
    endfunction

    // Index of a word inside a register array, or a miss
    function automatic logic array_hit(input logic [EVR_AW-1:0] addr,
                                       input logic [EVR_AW-1:0] base,
                                       output logic [2:0]       idx);
        logic [EVR_AW-1:0] delta;
        delta = addr - base;
        idx   = delta[4:2];
        array_hit = (addr >= base)
                 && (delta[1:0] == 2'h0)
                 && (delta < EVR_OFS_STRIDE * EVR_NUM_OUT);
    endfunction

    // --------------------------------------------------------------
    // Input gathering and synchronisation
    // --------------------------------------------------------------

    evr_sync_if syncBus ();

    evr_vec_t rawIn;      // All inputs as they arrive
    evr_vec_t syncIn;     // All inputs after synchroniser

    // Pads are watched whatever function the pin serves
    assign rawIn         = {pinEvIn, intEvIn};
    assign syncBus.rawIn = rawIn;
    assign syncIn        = syncBus.syncOut;

    // Synchroniser bank for the register side
    evr_sync uSync (
        .clk      (clk),
        .rst_b    (rst_b),
        .syncPort (syncBus.sync)
    );

    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------

    evr_state_t st;
    evr_state_t next_st;

    evr_vec_t               syncLevel;  // Active-high level, synchronised
    evr_vec_t               riseEvent;  // Edge into the active level
    evr_vec_t               clearMask;  // Bits software clears this cycle
    evr_vec_t               syncCond;   // Condition seen by status reads
    logic [EVR_NUM_OUT-1:0] syncLines;  // Output lines seen by status reads
    logic [EVR_DW-1:0]      readMux;    // Word selected by read address
    logic                   wrOutEn;    // Write hits an output enable
    logic [2:0]             wrIdx;      // Output enable index written
    logic                   rdOutEn;    // Read hits an output enable
    logic [2:0]             rdEnIdx;    // Output enable index read
    logic                   rdOutSt;    // Read hits an output status
    logic [2:0]             rdStIdx;    // Output status index read

    // Synchronised event conditions, edges and routed lines
    always_comb begin
        syncLevel = active_level(syncIn, st.polarity);
        riseEvent = syncLevel & ~st.prevLevel;
        syncCond  = event_cond(st.mode, st.latched, syncLevel);
        syncLines = route_out(syncCond, st.globalEn, st.outEn);
    end

    // Address decode for the output arrays
    always_comb begin
        wrOutEn = array_hit(regAddr, EVR_OFS_OUTEN, wrIdx);
        rdOutEn = array_hit(regAddr, EVR_OFS_OUTEN, rdEnIdx);
        rdOutSt = array_hit(regAddr, EVR_OFS_OUTST, rdStIdx);
    end

    // Read data multiplexer, unmapped addresses read zero
    always_comb begin
        readMux = EVR_RST_ZERO;
        if (rdOutEn) begin
            readMux = st.outEn[rdEnIdx];
        end else if (rdOutSt) begin
            readMux = syncCond & st.globalEn & st.outEn[rdStIdx];
        end else begin
            case (regAddr)
                EVR_OFS_POLARITY: readMux = st.polarity;
                EVR_OFS_MODE:     readMux = st.mode;
                EVR_OFS_GLOBAL:   readMux = st.globalEn;
                EVR_OFS_LATCH:    readMux = st.latched;
                EVR_OFS_RAW:      readMux = syncCond;
                EVR_OFS_SUMMARY:  readMux = {{(EVR_DW-EVR_NUM_OUT){1'b0}}, syncLines};
                default:          readMux = EVR_RST_ZERO;
            endcase
        end
    end

    // Software clear of latched events, write one to clear
    always_comb begin
        clearMask = '0;
        if (regWr && (regAddr == EVR_OFS_LATCH)) begin
            clearMask = regWrData;
        end
    end

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb begin
        next_st = st;

        // Edge memory for latched capture
        next_st.prevLevel = syncLevel;

        // A new edge wins over a clear in the same cycle
        next_st.latched = (st.latched & ~clearMask) | (riseEvent & st.mode);

        // Configuration writes
        if (regWr) begin
            case (regAddr)
                EVR_OFS_POLARITY: next_st.polarity = regWrData;
                EVR_OFS_MODE:     next_st.mode     = regWrData;
                EVR_OFS_GLOBAL:   next_st.globalEn = regWrData;
                default:          next_st.polarity = st.polarity;
            endcase
            if (wrOutEn) begin
                next_st.outEn[wrIdx] = regWrData;
            end
        end

        // Read data stands only in the cycle after the strobe
        next_st.rdData = regRd ? readMux : EVR_RST_ZERO;
    end

    // State register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st.polarity  <= EVR_RST_POLARITY;
            st.mode      <= EVR_RST_MODE;
            st.globalEn  <= EVR_RST_GLOBAL;
            st.latched   <= EVR_RST_ZERO;
            st.prevLevel <= EVR_RST_ZERO;
            st.outEn     <= {EVR_NUM_OUT{EVR_RST_OUTEN}};
            st.rdData    <= EVR_RST_ZERO;
        end else begin
            st <= next_st;
        end
    end

    // --------------------------------------------------------------
    // Output lines
    // --------------------------------------------------------------

    evr_vec_t               liveLevel;  // Active-high level straight from inputs
    evr_vec_t               liveCond;   // Condition with no clock in the path of direct inputs
    logic [EVR_NUM_OUT-1:0] liveLines;  // Routed lines

    // Direct events reach the lines without any clock edge
    always_comb begin
        liveLevel = active_level(rawIn, st.polarity);
        liveCond  = event_cond(st.mode, st.latched, liveLevel);
        liveLines = route_out(liveCond, st.globalEn, st.outEn);
    end

    // Four interrupt lines and the wake-up line
    assign irqOut    = liveLines[EVR_NUM_IRQ-1:0];
    assign wakeOut   = liveLines[EVR_WAKE_IDX];
    assign regRdData = st.rdData;

endmodule // event_router

/* sim/evr_props.sv */
// Concurrent checks on the event router ports
`timescale 1ns/1ps
module evr_props
    import evr_pkg::*;
(
    input wire logic                   clk,       // System clock
    input wire logic                   rst_b,     // Reset, active low
    input wire logic [EVR_NUM_INT-1:0] intEvIn,   // Internal events
    input wire logic [EVR_NUM_PIN-1:0] pinEvIn,   // Pin events
    input wire logic [EVR_AW-1:0]      regAddr,   // Register address
    input wire logic [EVR_DW-1:0]      regWrData, // Write data
    input wire logic                   regWr,     // Write strobe
    input wire logic                   regRd,     // Read strobe
    input wire logic [EVR_DW-1:0]      regRdData, // Read data
    input wire logic [EVR_NUM_IRQ-1:0] irqOut,    // Interrupt lines
    input wire logic                   wakeOut    // Wake-up line
);
    evr_vec_t               pol;
    evr_vec_t               mode;
    evr_vec_t               glob;
    evr_vec_t               en [EVR_NUM_OUT];
    logic                   latchUsed;
    logic [EVR_NUM_OUT-1:0] lines;
    logic [EVR_NUM_OUT-1:0] anyEn;
    logic [EVR_NUM_OUT-1:0] expLines;
    assign lines = {wakeOut, irqOut};
    // Shadow of configuration writes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pol <= EVR_RST_POLARITY;
            mode <= EVR_RST_MODE;
            glob <= EVR_RST_GLOBAL;
            latchUsed <= 1'b0;
            for (int k = 0; k < EVR_NUM_OUT; k++) en[k] <= EVR_RST_OUTEN;
        end else if (regWr) begin
            if (regAddr == EVR_OFS_POLARITY) pol <= regWrData;
            if (regAddr == EVR_OFS_MODE) mode <= regWrData;
            if (regAddr == EVR_OFS_MODE && regWrData != '0) latchUsed <= 1'b1;
            if (regAddr == EVR_OFS_GLOBAL) glob <= regWrData;
            for (int k = 0; k < EVR_NUM_OUT; k++) begin
                if (regAddr == EVR_OFS_OUTEN + 8'(4 * k)) en[k] <= regWrData;
            end
        end
    end
    // Expected lines for direct events and enable summary
    always_comb begin
        for (int k = 0; k < EVR_NUM_OUT; k++) begin
            anyEn[k] = |(glob & en[k]);
            expLines[k] = |(~({pinEvIn, intEvIn} ^ pol) & glob & en[k]);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence sWrGlob; regWr && regAddr == EVR_OFS_GLOBAL; endsequence
    sequence sRdGlob; regRd && regAddr == EVR_OFS_GLOBAL; endsequence
    sequence sRise;
        mode == '1 && pol[0] && glob[0] && en[0][0] && $rose(intEvIn[0]) ##1 intEvIn[0] [*2];
    endsequence
    a_wr_readback: assert property (sWrGlob ##1 sRdGlob |=> regRdData == $past(regWrData, 2))
        else $error("global enable read back differs");
    a_read_idle: assert property (!regRd |=> regRdData == '0)
        else $error("read data not zero outside read");
    a_unmapped_read: assert property (regRd && regAddr == 8'hFC |=> regRdData == '0)
        else $error("unmapped read not zero");
    a_reset_quiet: assert property ($rose(rst_b) |-> lines == '0)
        else $error("line active after reset");
    a_mask_blocks: assert property ((lines & ~anyEn) == '0)
        else $error("masked line active");
    a_direct_route: assert property (mode == '0 && !latchUsed |-> lines == expLines)
        else $error("direct routing wrong");
    a_latch_hold: assert property (mode == '1 && !regWr |=> (lines & $past(lines)) == $past(lines))
        else $error("latched line dropped without clear");
    a_latch_rise: assert property (sRise |=> irqOut[0])
        else $error("latched event not seen in time");
endmodule // evr_props
bind event_router evr_props u_props (.clk(clk), .rst_b(rst_b), .intEvIn(intEvIn),
    .pinEvIn(pinEvIn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .irqOut(irqOut), .wakeOut(wakeOut));

/* sim/evr_partner.sv */
// Clock unit model that stops and restarts the router clock
`timescale 1ns/1ps
module evr_partner
(
    input  wire logic clk,      // Free-running source clock
    input  wire logic rst_b,    // Reset, active low
    input  wire logic sleepReq, // Request to stop clocks
    input  wire logic wakeOut,  // Wake-up line from router
    output logic      clkOn,    // Module clock enabled
    output logic      gatedClk  // Clock to the router
);
    // Gate enable moves while the source clock is low, so no short pulse
    always @(negedge clk or negedge rst_b) begin
        if (!rst_b) clkOn <= 1'b1;
        else if (wakeOut) clkOn <= 1'b1;
        else if (sleepReq) clkOn <= 1'b0;
    end
    assign gatedClk = clk & clkOn;
endmodule // evr_partner

/* sim/tb_event_router.sv */
// Self-checking bench for the event router
`timescale 1ns/1ps
module tb_event_router
    import evr_pkg::*;
;
    logic clk, rst_b, regWr, regRd, sleepReq, wakeOut, clkOn, gatedClk;
    logic [EVR_NUM_INT-1:0] intEvIn;
    logic [EVR_NUM_PIN-1:0] pinEvIn;
    logic [EVR_AW-1:0]      regAddr;
    logic [EVR_DW-1:0]      regWrData, regRdData;
    logic [EVR_NUM_IRQ-1:0] irqOut;
    logic [EVR_NUM_OUT-1:0] lines;
    int                     errCount, checked, cycles;
    assign lines = {wakeOut, irqOut};
    event_router DUT (.clk(gatedClk), .rst_b(rst_b), .intEvIn(intEvIn), .pinEvIn(pinEvIn),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .irqOut(irqOut), .wakeOut(wakeOut));
    evr_partner u_partner (.clk(clk), .rst_b(rst_b), .sleepReq(sleepReq), .wakeOut(wakeOut),
        .clkOn(clkOn), .gatedClk(gatedClk));
    task automatic printVerdict();
        if (errCount == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic cmpReg(string n, logic [EVR_DW-1:0] e, logic [EVR_DW-1:0] g);
        checked++;
        if (g !== e) begin
            errCount++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cmpLines(string n, logic [EVR_NUM_OUT-1:0] e);
        #1;
        checked++;
        if (lines !== e) begin
            errCount++;
            $display("mismatch %s expected %h seen %h", n, e, lines);
        end
    endtask
    task automatic wr(logic [EVR_AW-1:0] a, logic [EVR_DW-1:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(string n, logic [EVR_AW-1:0] a, logic [EVR_DW-1:0] e);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 cmpReg(n, e, regRdData);
    endtask
    // Write, then read the same word back with no gap between strobes
    task automatic wrRd(string n, logic [EVR_AW-1:0] a, logic [EVR_DW-1:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 cmpReg(n, d, regRdData);
    endtask
    // Free-running source clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            errCount++;
            printVerdict();
        end
    end
    // Main sequence
    initial begin
        {rst_b, regWr, regRd, sleepReq, intEvIn, pinEvIn, regAddr, regWrData} = '0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        rd("polarity", EVR_OFS_POLARITY, EVR_RST_POLARITY);
        rd("mode", EVR_OFS_MODE, EVR_RST_MODE);
        rd("global", EVR_OFS_GLOBAL, EVR_RST_GLOBAL);
        rd("unmapped", 8'hFC, EVR_RST_ZERO);
        wrRd("global", EVR_OFS_GLOBAL, 32'hFFFFFFFF);
        for (int k = 0; k < EVR_NUM_OUT; k++) begin
            rd("outen", EVR_OFS_OUTEN + 8'(4 * k), EVR_RST_OUTEN);
            wr(EVR_OFS_OUTEN + 8'(4 * k), 32'h101 << k);
            rd("outen", EVR_OFS_OUTEN + 8'(4 * k), 32'h101 << k);
        end
        // Each output from its internal and its pin source
        for (int k = 0; k < EVR_NUM_OUT; k++) begin
            @(posedge clk);
            intEvIn <= 8'(1 << k);
            cmpLines("internal", 5'(1 << k));
            @(posedge clk);
            intEvIn <= '0;
            pinEvIn <= 24'(1 << k);
            cmpLines("pin", 5'(1 << k));
            repeat (2) @(posedge clk);
            rd("status", EVR_OFS_OUTST + 8'(4 * k), 32'h100 << k);
            rd("raw", EVR_OFS_RAW, 32'h100 << k);
            rd("summary", EVR_OFS_SUMMARY, 32'(1 << k));
            pinEvIn <= '0;
            cmpLines("release", 5'h00);
        end
        // One input on two outputs, global mask, polarity
        wr(EVR_OFS_OUTEN + 8'h04, 32'h00000103);
        intEvIn <= 8'h01;
        cmpLines("fanout", 5'h03);
        wr(EVR_OFS_GLOBAL, 32'hFFFFFFFE);
        cmpLines("global mask", 5'h00);
        wr(EVR_OFS_GLOBAL, 32'hFFFFFFFF);
        wr(EVR_OFS_POLARITY, 32'hFFFFFFFE);
        cmpLines("low active idle", 5'h00);
        intEvIn <= 8'h00;
        cmpLines("low active", 5'h03);
        wr(EVR_OFS_POLARITY, 32'hFFFFFFFF);
        cmpLines("polarity back", 5'h00);
        // Latched event held until cleared
        wr(EVR_OFS_MODE, 32'hFFFFFFFF);
        intEvIn <= 8'h01;
        repeat (3) @(posedge clk);
        cmpLines("latched", 5'h03);
        intEvIn <= 8'h00;
        repeat (3) @(posedge clk);
        cmpLines("held", 5'h03);
        rd("latch", EVR_OFS_LATCH, 32'h00000001);
        wr(EVR_OFS_LATCH, 32'h00000001);
        cmpLines("cleared", 5'h00);
        rd("latch", EVR_OFS_LATCH, EVR_RST_ZERO);
        // Suspend, then wake from a pin with the clock stopped
        wr(EVR_OFS_MODE, EVR_RST_MODE);
        sleepReq <= 1'b1;
        @(posedge clk);
        sleepReq <= 1'b0;
        repeat (4) @(posedge clk);
        cmpReg("clock stopped", 32'h0, 32'(clkOn));
        pinEvIn <= 24'h000010;
        cmpLines("wake", 5'h10);
        @(posedge clk);
        cmpReg("clock restarted", 32'h1, 32'(clkOn));
        pinEvIn <= '0;
        rst_b <= 1'b0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        rd("global", EVR_OFS_GLOBAL, EVR_RST_GLOBAL);
        cmpLines("after reset", 5'h00);
        printVerdict();
    end
endmodule // tb_event_router
